// [bench/i2c_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// bus master, open drain
// ----
module i2c_host_model (
	input wire logic i_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_low,
	output logic o_sda_low,
	output logic o_stuck
);
	initial begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
		o_stuck = 1'b0;
	end
	task automatic hold();
		repeat (5) @(posedge i_clk);
	endtask
	// release clock, wait out stretching
	task automatic rise();
		int n;
		o_scl_low <= 1'b0;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_scl !== 1'b1 && n < 3000);
		if (n >= 3000) o_stuck <= 1'b1;
		hold();
	endtask
	task automatic fall();
		o_scl_low <= 1'b1;
		hold();
	endtask
	task automatic start();
		o_sda_low <= 1'b0;
		hold();
		rise();
		o_sda_low <= 1'b1;
		hold();
		fall();
	endtask
	task automatic stop();
		o_sda_low <= 1'b1;
		hold();
		rise();
		o_sda_low <= 1'b0;
		hold();
	endtask
	// nine bits msb first, line sampled late in high phase
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			o_sda_low <= !tx[i];
			hold();
			rise();
			rx[i] = i_sda;
			fall();
		end
	endtask
endmodule
`default_nettype wire

// [bench/test_touch_i2c_port.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// port testbench
// ----
module test_touch_i2c_port;
	import touch_i2c_pkg::*;
	logic clk = 1'b0;
	logic arst_n, addr_strap, comm_strap, flavor_strap, wr_ready;
	logic scl_oe, sda_oe, usb_sel, hid_sel, pop, pend_n, wr_valid, crc_fail, stuck, h_scl, h_sda;
	logic pend_oe, scl_o, sda_o;
	logic stretched = 1'b0;
	logic [7:0] pops = 8'h00;
	logic [7:0] msg_cnt, wr_data;
	logic [15:0] rd_addr, wr_addr;
	logic [23:0] wq[$];
	int err_total = 0;
	int cmp_count = 0;
	wire logic scl = !(h_scl || scl_oe);
	wire logic sda = !(h_sda || sda_oe);
	always #5 clk = ~clk;
	function automatic logic [7:0] mem(input logic [15:0] a);
		return a[7:0] + 8'h31;
	endfunction
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		c = c ^ d;
		for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
		return c;
	endfunction
	touch_i2c_port DUT (
		.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_SCL(scl), .O_SCL_O(scl_o), .O_SCL_OE(scl_oe),
		.I_SDA(sda), .O_SDA_O(sda_o), .O_SDA_OE(sda_oe), .I_SLAVE_ADDR_STRAP(addr_strap),
		.I_COMM_SELECT_STRAP(comm_strap), .I_I2C_FLAVOR_STRAP(flavor_strap),
		.O_USB_SEL(usb_sel), .O_HID_SEL(hid_sel), .O_RD_ADDR(rd_addr), .I_RD_DATA(mem(rd_addr)),
		.I_MSG_COUNT(msg_cnt), .O_MSG_POP(pop), .O_MSG_PENDING_N(pend_n),
		.O_MSG_PENDING_OE(pend_oe),
		.O_WR_VALID(wr_valid), .I_WR_READY(wr_ready), .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data),
		.O_CRC_FAIL(crc_fail));
	i2c_host_model host (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_low(h_scl),
		.o_sda_low(h_sda), .o_stuck(stuck));
	// core side: word sink, message queue
	always @(posedge clk) begin
		if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
		if (pop) pops <= pops + 8'h01;
		if (pop) msg_cnt <= msg_cnt - 8'h01;
		if (scl_oe) stretched <= 1'b1;
	end
	always @(posedge stuck) begin
		err_total++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic do_reset(input logic [2:0] s);
		arst_n <= 1'b0;
		{addr_strap, comm_strap, flavor_strap} <= s;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic wb(input logic [7:0] d, input logic ack);
		logic [8:0] rx;
		host.xfer({d, 1'b1}, rx);
		check("ack", rx[0], !ack);
	endtask
	task automatic rb(input logic [7:0] exp, input logic last);
		logic [8:0] rx;
		host.xfer({8'hff, last}, rx);
		check("read", rx[8:1], exp);
	endtask
	task automatic go(input logic [6:0] sla, input logic rd, input logic ack);
		host.start();
		wb({sla, rd}, ack);
	endtask
	task automatic set_ptr(input logic [15:0] p);
		go(SLAVE_ADDR_LOW, 1'b0, 1'b1);
		wb(p[7:0], 1'b1);
		wb(p[15:8], 1'b1);
	endtask
	initial begin
		logic [7:0] c;
		int i, k, rec;
		wr_ready <= 1'b0;
		msg_cnt <= 8'h00;
		rec = MSG_REC_SIZE - 8'h01;
		do_reset(3'b000);
		check("idle", {pend_n, pend_oe, wr_valid, crc_fail, usb_sel, hid_sel, scl_o, sda_o}, 8'h80);
		go(SLAVE_ADDR_HIGH, 1'b0, 1'b0);
		host.stop();
		fork
			begin
				repeat (1000) @(posedge clk);
				wr_ready <= 1'b1;
			end
		join_none
		set_ptr(16'h1234);
		for (i = 0; i < 4; i++) wb(8'ha0 + 8'(i), 1'b1);
		host.stop();
		check("stretch", stretched, 1'b1);
		for (i = 0; i < 4; i++) check("word", wq.pop_front(), {16'h1234 + 16'(i), 8'ha0 + 8'(i)});
		for (k = 0; k < 2; k++) begin
			go(SLAVE_ADDR_LOW, 1'b1, 1'b1);
			rb(mem(16'h1234), 1'b0);
			rb(mem(16'h1235), 1'b1);
			host.stop();
		end
		for (k = 0; k < 2; k++) begin
			c = crc8(crc8(crc8(CRC_INIT, 8'h34), 8'h92), 8'h96);
			set_ptr(16'h9234);
			wb(8'h96, 1'b1);
			wb(c ^ 8'(k), 1'b1);
			host.stop();
			check("crc flag", crc_fail, k[0]);
			check("csum word", wq.pop_front(), 24'h123496);
		end
		msg_cnt <= 8'h02;
		set_ptr(MSG_COUNT_ADDR);
		host.stop();
		check("pending", {pend_n, pend_oe}, 2'b01);
		go(SLAVE_ADDR_LOW, 1'b1, 1'b1);
		rb(8'h02, 1'b0);
		for (i = 0; i < 2 * rec; i++) rb(mem(MSG_RECORD_ADDR + 16'(i % rec)), i == 2 * rec - 1);
		host.stop();
		check("pops", pops, 8'h02);
		check("pending", {pend_n, pend_oe}, 2'b10);
		go(SLAVE_ADDR_LOW, 1'b1, 1'b1);
		rb(8'h00, 1'b1);
		host.stop();
		msg_cnt <= 8'h01;
		set_ptr(MSG_COUNT_ADDR | 16'h8000);
		host.stop();
		go(SLAVE_ADDR_LOW, 1'b1, 1'b1);
		rb(8'h01, 1'b0);
		c = CRC_INIT;
		for (i = 0; i < rec; i++) begin
			rb(mem(MSG_RECORD_ADDR + 16'(i)), 1'b0);
			c = crc8(c, mem(MSG_RECORD_ADDR + 16'(i)));
		end
		rb(c, 1'b1);
		host.stop();
		for (k = 0; k < 3; k++) begin
			do_reset(3'b100 >> k);
			check("straps", {usb_sel, hid_sel}, {k == 1, k == 2});
			go(k == 0 ? SLAVE_ADDR_HIGH : SLAVE_ADDR_LOW, 1'b0, k == 0);
			host.stop();
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [bench/touch_i2c_port_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// port checker
// ----
module touch_i2c_port_check (
	input wire logic I_SYS_CLK,
	input wire logic I_ARST_N,
	input wire logic I_SCL,
	input wire logic I_SDA,
	input wire logic O_SCL_OE,
	input wire logic O_SDA_OE,
	input wire logic O_USB_SEL,
	input wire logic O_HID_SEL,
	input wire logic [touch_i2c_pkg::BYTE_W-1:0] I_MSG_COUNT,
	input wire logic O_MSG_PENDING_N,
	input wire logic O_MSG_POP,
	input wire logic O_WR_VALID,
	input wire logic I_WR_READY,
	input wire logic [touch_i2c_pkg::PTR_W-1:0] O_WR_ADDR,
	input wire logic [touch_i2c_pkg::BYTE_W-1:0] O_WR_DATA,
	input wire logic O_CRC_FAIL
);
	import touch_i2c_pkg::*;
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_ARST_N);
	sequence s_stall;
		O_WR_VALID && !I_WR_READY;
	endsequence
	sequence s_queued;
		I_MSG_COUNT != 8'h00;
	endsequence
	a_pending_low: assert property (s_queued |=> !O_MSG_PENDING_N)
		else $error("pending line not low");
	a_pending_high: assert property (I_MSG_COUNT == 8'h00 |=> O_MSG_PENDING_N)
		else $error("pending line low with empty queue");
	a_word_holds: assert property (s_stall |=> O_WR_VALID && $stable(O_WR_ADDR) && $stable(O_WR_DATA))
		else $error("write word lost while stalled");
	a_flag_stripped: assert property (O_WR_VALID |-> !O_WR_ADDR[PTR_W-1])
		else $error("checksum flag in write address");
	a_pop_single: assert property (O_MSG_POP |=> !O_MSG_POP)
		else $error("pop longer than one cycle");
	a_bus_ignored: assert property (O_USB_SEL || O_HID_SEL |-> !O_SDA_OE && !O_SCL_OE)
		else $error("bus driven while disabled");
	a_stretch_cause: assert property ($rose(O_SCL_OE) |-> O_WR_VALID)
		else $error("stretch without queued word");
	a_crc_at_stop: assert property ($changed(O_CRC_FAIL) |-> I_SCL && I_SDA)
		else $error("crc flag changed outside stop");
endmodule
bind touch_i2c_port touch_i2c_port_check u_check (
	.I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N), .I_SCL(I_SCL), .I_SDA(I_SDA),
	.O_SCL_OE(O_SCL_OE), .O_SDA_OE(O_SDA_OE), .O_USB_SEL(O_USB_SEL), .O_HID_SEL(O_HID_SEL),
	.I_MSG_COUNT(I_MSG_COUNT), .O_MSG_PENDING_N(O_MSG_PENDING_N), .O_MSG_POP(O_MSG_POP),
	.O_WR_VALID(O_WR_VALID), .I_WR_READY(I_WR_READY), .O_WR_ADDR(O_WR_ADDR),
	.O_WR_DATA(O_WR_DATA), .O_CRC_FAIL(O_CRC_FAIL));
`default_nettype wire

// [hw/crc8_step.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// one byte of crc8, msb first
// ----------------------------------------
module crc8_step (
	input wire logic [touch_i2c_pkg::BYTE_W-1:0] i_seed,
	input wire logic [touch_i2c_pkg::BYTE_W-1:0] i_byte,
	output logic [touch_i2c_pkg::BYTE_W-1:0] o_crc
);
	import touch_i2c_pkg::*;

	always_comb begin
		logic [7:0] c;
		c = i_seed ^ i_byte;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		o_crc = c;
	end
endmodule

`default_nettype wire

// [hw/touch_i2c_pkg.sv]
package touch_i2c_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int BYTE_W = 8;
	localparam int PTR_W = 16;
	localparam int ADDR7_W = 7;

	// ----------------------------------------
	// slave addresses
	// ----------------------------------------
	localparam logic [6:0] SLAVE_ADDR_LOW = 7'h4a;
	localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h4b;
	localparam int RW_BIT_POS = 0;

	// ----------------------------------------
	// pointer layout and reset values
	// ----------------------------------------
	localparam int CSUM_FLAG_POS = 7;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	localparam logic [15:0] MSG_COUNT_ADDR = 16'h0100;
	localparam logic [15:0] MSG_RECORD_ADDR = 16'h0110;
	localparam logic [7:0] MSG_REC_SIZE = 8'h0a;

	// ----------------------------------------
	// checksum
	// ----------------------------------------
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// ----------------------------------------
	// protocol states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RECV,
		ST_ACK_SETUP,
		ST_ACK,
		ST_SEND,
		ST_MACK,
		ST_MLOAD
	} i2c_state_t;

endpackage

// [hw/touch_i2c_port.sv]
`timescale 1ns/1ns
`default_nettype none

module touch_i2c_port (
	input wire logic I_SYS_CLK,
	input wire logic I_ARST_N,
	input wire logic I_SCL,
	output logic O_SCL_O,
	output logic O_SCL_OE,
	input wire logic I_SDA,
	output logic O_SDA_O,
	output logic O_SDA_OE,
	input wire logic I_SLAVE_ADDR_STRAP,
	input wire logic I_COMM_SELECT_STRAP,
	input wire logic I_I2C_FLAVOR_STRAP,
	output logic O_USB_SEL,
	output logic O_HID_SEL,
	output logic [touch_i2c_pkg::PTR_W-1:0] O_RD_ADDR,
	input wire logic [touch_i2c_pkg::BYTE_W-1:0] I_RD_DATA,
	input wire logic [touch_i2c_pkg::BYTE_W-1:0] I_MSG_COUNT,
	output logic O_MSG_POP,
	output logic O_MSG_PENDING_N,
	output logic O_MSG_PENDING_OE,
	output logic O_WR_VALID,
	input wire logic I_WR_READY,
	output logic [touch_i2c_pkg::PTR_W-1:0] O_WR_ADDR,
	output logic [touch_i2c_pkg::BYTE_W-1:0] O_WR_DATA,
	output logic O_CRC_FAIL
);
	import touch_i2c_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	i2c_state_t state_ff;
	logic scl_q_ff;
	logic sda_q_ff;
	logic low_ff;
	logic strap_done_ff;
	logic addr_hi_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic addr_phase_ff;
	logic rw_ff;
	logic [1:0] byte_idx_ff;
	logic [7:0] ptr_lo_ff;
	logic [15:0] ptr_ff;
	logic [15:0] start_ff;
	logic csum_ff;
	logic [7:0] held_ff;
	logic held_v_ff;
	logic [7:0] crc_ff;
	logic push_pend_ff;
	logic [15:0] push_addr_ff;
	logic [7:0] push_data_ff;
	logic msg_rd_ff;
	logic head_ff;
	logic [7:0] rec_idx_ff;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic enabled;
	logic [6:0] my_addr;
	logic addr_match;
	logic byte_rx_evt;
	logic addr_wr_evt;
	logic addr_rd_evt;
	logic mack_evt;
	logic load_evt;
	logic crc_slot;
	logic [7:0] rec_last;
	logic [7:0] tx_byte;
	logic [7:0] crc_byte;
	logic [7:0] crc_seed;
	logic [7:0] crc_nxt;
	logic [15:0] nxt_ptr;

	wr_word_if wr_if ();

	// ----------------------------------------
	// bus conditions
	// ----------------------------------------
	assign scl_rise = I_SCL & ~scl_q_ff;
	assign scl_fall = ~I_SCL & scl_q_ff;
	assign start_cond = scl_q_ff & I_SCL & sda_q_ff & ~I_SDA;
	assign stop_cond = scl_q_ff & I_SCL & ~sda_q_ff & I_SDA;

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
			low_ff <= 1'b0;
		end else begin
			scl_q_ff <= I_SCL;
			sda_q_ff <= I_SDA;
			low_ff <= 1'b0;
		end
	end

	assign O_SCL_O = low_ff;
	assign O_SDA_O = low_ff;

	// ----------------------------------------
	// straps, caught after reset release
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			strap_done_ff <= 1'b0;
			addr_hi_ff <= 1'b0;
			O_USB_SEL <= 1'b0;
			O_HID_SEL <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_done_ff <= 1'b1;
			addr_hi_ff <= I_SLAVE_ADDR_STRAP;
			O_USB_SEL <= I_COMM_SELECT_STRAP;
			O_HID_SEL <= ~I_COMM_SELECT_STRAP & I_I2C_FLAVOR_STRAP;
		end
	end

	assign enabled = strap_done_ff & ~O_USB_SEL & ~O_HID_SEL;
	assign my_addr = addr_hi_ff ? SLAVE_ADDR_HIGH : SLAVE_ADDR_LOW;
	assign addr_match = shift_ff[7:1] == my_addr;

	// ----------------------------------------
	// events
	// ----------------------------------------
	assign byte_rx_evt = (state_ff == ST_ACK_SETUP) & scl_fall & ~addr_phase_ff;
	assign addr_wr_evt = (state_ff == ST_ACK_SETUP) & scl_fall & addr_phase_ff & addr_match
		& ~shift_ff[RW_BIT_POS];
	assign addr_rd_evt = (state_ff == ST_ACK_SETUP) & scl_fall & addr_phase_ff & addr_match
		& shift_ff[RW_BIT_POS];
	assign mack_evt = (state_ff == ST_MACK) & scl_rise;
	assign load_evt = scl_fall & (((state_ff == ST_ACK) & rw_ff) | (state_ff == ST_MLOAD));

	// ----------------------------------------
	// read byte source
	// ----------------------------------------
	assign rec_last = csum_ff ? MSG_REC_SIZE - 8'h01 : MSG_REC_SIZE - 8'h02;
	assign crc_slot = msg_rd_ff & ~head_ff & csum_ff & (rec_idx_ff == MSG_REC_SIZE - 8'h01);

	always_comb begin
		if (msg_rd_ff && head_ff) begin
			tx_byte = I_MSG_COUNT;
		end else if (crc_slot) begin
			tx_byte = crc_ff;
		end else begin
			tx_byte = I_RD_DATA;
		end
	end

	// ----------------------------------------
	// bit engine
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_ff <= ST_IDLE;
			bit_cnt_ff <= 3'h0;
			shift_ff <= 8'h00;
			addr_phase_ff <= 1'b0;
			rw_ff <= 1'b0;
			O_SDA_OE <= 1'b0;
		end else if (start_cond && enabled) begin
			state_ff <= ST_RECV;
			bit_cnt_ff <= 3'h0;
			addr_phase_ff <= 1'b1;
			O_SDA_OE <= 1'b0;
		end else if (stop_cond) begin
			state_ff <= ST_IDLE;
			O_SDA_OE <= 1'b0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					O_SDA_OE <= 1'b0;
				end
				ST_RECV: begin
					if (scl_rise) begin
						shift_ff <= {shift_ff[6:0], I_SDA};
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == 3'h7) begin
							state_ff <= ST_ACK_SETUP;
						end
					end
				end
				ST_ACK_SETUP: begin
					if (scl_fall) begin
						if (!addr_phase_ff || addr_match) begin
							O_SDA_OE <= 1'b1;
							state_ff <= ST_ACK;
							if (addr_phase_ff) begin
								rw_ff <= shift_ff[RW_BIT_POS];
							end
						end else begin
							state_ff <= ST_IDLE;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						addr_phase_ff <= 1'b0;
						bit_cnt_ff <= 3'h0;
						if (rw_ff) begin
							O_SDA_OE <= ~tx_byte[7];
							shift_ff <= {tx_byte[6:0], 1'b0};
							state_ff <= ST_SEND;
						end else begin
							O_SDA_OE <= 1'b0;
							state_ff <= ST_RECV;
						end
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						if (bit_cnt_ff == 3'h7) begin
							O_SDA_OE <= 1'b0;
							state_ff <= ST_MACK;
						end else begin
							O_SDA_OE <= ~shift_ff[7];
							shift_ff <= {shift_ff[6:0], 1'b0};
							bit_cnt_ff <= bit_cnt_ff + 3'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						state_ff <= I_SDA ? ST_IDLE : ST_MLOAD;
					end
				end
				ST_MLOAD: begin
					if (scl_fall) begin
						O_SDA_OE <= ~tx_byte[7];
						shift_ff <= {tx_byte[6:0], 1'b0};
						bit_cnt_ff <= 3'h0;
						state_ff <= ST_SEND;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// address pointer and write sequencing
	// ----------------------------------------
	assign nxt_ptr = ptr_ff + 16'h0001;

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			byte_idx_ff <= 2'h0;
			ptr_lo_ff <= 8'h00;
			ptr_ff <= PTR_RESET;
			start_ff <= PTR_RESET;
			csum_ff <= 1'b0;
			held_ff <= 8'h00;
			held_v_ff <= 1'b0;
			O_CRC_FAIL <= 1'b0;
		end else if (stop_cond) begin
			ptr_ff <= start_ff;
			held_v_ff <= 1'b0;
			if (!rw_ff && held_v_ff && byte_idx_ff == 2'h2 && csum_ff) begin
				O_CRC_FAIL <= held_ff != crc_ff;
			end
		end else if (addr_wr_evt) begin
			byte_idx_ff <= 2'h0;
			held_v_ff <= 1'b0;
		end else if (byte_rx_evt) begin
			unique case (byte_idx_ff)
				2'h0: begin
					ptr_lo_ff <= shift_ff;
					byte_idx_ff <= 2'h1;
				end
				2'h1: begin
					ptr_ff <= {1'b0, shift_ff[6:0], ptr_lo_ff};
					start_ff <= {1'b0, shift_ff[6:0], ptr_lo_ff};
					csum_ff <= shift_ff[CSUM_FLAG_POS];
					byte_idx_ff <= 2'h2;
				end
				default: begin
					if (!csum_ff || held_v_ff) begin
						ptr_ff <= nxt_ptr;
					end
					if (csum_ff) begin
						held_ff <= shift_ff;
						held_v_ff <= 1'b1;
					end
				end
			endcase
		end else if (mack_evt) begin
			if (I_SDA) begin
				ptr_ff <= start_ff;
			end else if (!msg_rd_ff) begin
				ptr_ff <= nxt_ptr;
			end
		end
	end

	// ----------------------------------------
	// crc for writes and message reads
	// ----------------------------------------
	assign crc_byte = rw_ff ? tx_byte : ((byte_idx_ff == 2'h2) ? held_ff : shift_ff);
	assign crc_seed = (rw_ff && rec_idx_ff == 8'h00) ? CRC_INIT : crc_ff;

	crc8_step u_crc (
		.i_seed(crc_seed),
		.i_byte(crc_byte),
		.o_crc(crc_nxt)
	);

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			crc_ff <= CRC_INIT;
		end else if (addr_wr_evt) begin
			crc_ff <= CRC_INIT;
		end else if (byte_rx_evt && (byte_idx_ff != 2'h2 || held_v_ff)) begin
			crc_ff <= crc_nxt;
		end else if (load_evt && msg_rd_ff && !head_ff && !crc_slot) begin
			crc_ff <= crc_nxt;
		end
	end

	// ----------------------------------------
	// message read sequencing
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			msg_rd_ff <= 1'b0;
			head_ff <= 1'b0;
			rec_idx_ff <= 8'h00;
			O_MSG_POP <= 1'b0;
		end else begin
			O_MSG_POP <= 1'b0;
			if (addr_rd_evt) begin
				msg_rd_ff <= ptr_ff == MSG_COUNT_ADDR;
				head_ff <= 1'b1;
				rec_idx_ff <= 8'h00;
			end else if (mack_evt && msg_rd_ff) begin
				if (head_ff) begin
					head_ff <= 1'b0;
				end else if (rec_idx_ff == rec_last) begin
					rec_idx_ff <= 8'h00;
					O_MSG_POP <= 1'b1;
				end else begin
					rec_idx_ff <= rec_idx_ff + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_RD_ADDR <= PTR_RESET;
		end else if (msg_rd_ff && !head_ff) begin
			O_RD_ADDR <= MSG_RECORD_ADDR + {8'h00, rec_idx_ff};
		end else begin
			O_RD_ADDR <= ptr_ff;
		end
	end

	// ----------------------------------------
	// write push and clock stretch
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			push_pend_ff <= 1'b0;
			push_addr_ff <= PTR_RESET;
			push_data_ff <= 8'h00;
		end else if (byte_rx_evt && byte_idx_ff == 2'h2 && (!csum_ff || held_v_ff)) begin
			push_pend_ff <= 1'b1;
			push_addr_ff <= ptr_ff;
			push_data_ff <= csum_ff ? held_ff : shift_ff;
		end else if (wr_if.ready) begin
			push_pend_ff <= 1'b0;
		end
	end

	assign wr_if.valid = push_pend_ff;
	assign wr_if.addr = push_addr_ff;
	assign wr_if.data = push_data_ff;

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_SCL_OE <= 1'b0;
		end else begin
			O_SCL_OE <= push_pend_ff & ~wr_if.ready & ~I_SCL;
		end
	end

	wr_skid_buffer u_buf (
		.i_clk(I_SYS_CLK),
		.i_arst_n(I_ARST_N),
		.in_if(wr_if.snk),
		.o_valid(O_WR_VALID),
		.i_ready(I_WR_READY),
		.o_addr(O_WR_ADDR),
		.o_data(O_WR_DATA)
	);

	// ----------------------------------------
	// pending message line
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_MSG_PENDING_N <= 1'b1;
			O_MSG_PENDING_OE <= 1'b0;
		end else begin
			O_MSG_PENDING_N <= I_MSG_COUNT == 8'h00;
			O_MSG_PENDING_OE <= I_MSG_COUNT != 8'h00;
		end
	end
endmodule

`default_nettype wire

// [hw/wr_skid_buffer.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// two-entry buffer, outputs registered
// ----------------------------------------
module wr_skid_buffer (
	input wire logic i_clk,
	input wire logic i_arst_n,
	wr_word_if.snk in_if,
	output logic o_valid,
	input wire logic i_ready,
	output logic [touch_i2c_pkg::PTR_W-1:0] o_addr,
	output logic [touch_i2c_pkg::BYTE_W-1:0] o_data
);
	import touch_i2c_pkg::*;

	logic skid_v_ff;
	logic [PTR_W-1:0] skid_addr_ff;
	logic [BYTE_W-1:0] skid_data_ff;

	// full when the skid slot holds a word
	assign in_if.ready = ~skid_v_ff;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_valid <= 1'b0;
			o_addr <= PTR_RESET;
			o_data <= 8'h00;
			skid_v_ff <= 1'b0;
			skid_addr_ff <= PTR_RESET;
			skid_data_ff <= 8'h00;
		end else if (i_ready || !o_valid) begin
			if (skid_v_ff) begin
				o_valid <= 1'b1;
				o_addr <= skid_addr_ff;
				o_data <= skid_data_ff;
				skid_v_ff <= 1'b0;
			end else begin
				o_valid <= in_if.valid;
				o_addr <= in_if.addr;
				o_data <= in_if.data;
			end
		end else if (in_if.valid && !skid_v_ff) begin
			skid_v_ff <= 1'b1;
			skid_addr_ff <= in_if.addr;
			skid_data_ff <= in_if.data;
		end
	end
endmodule

`default_nettype wire

// [hw/wr_word_if.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// write word carrier
// ----------------------------------------
interface wr_word_if;
	logic valid;
	logic ready;
	logic [15:0] addr;
	logic [7:0] data;

	modport src (output valid, output addr, output data, input ready);
	modport snk (input valid, input addr, input data, output ready);
endinterface

`default_nettype wire
